// file: src/pcm_pkg.sv
// Shared constants and types of the protection and charge-mode control block.
// Assumes a single 10 MHz system clock and same-clock configuration inputs.
package pcm_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int SS_TIME_US = 1000;
    localparam int SS_CYCLES = SS_TIME_US * CYC_PER_US;
    localparam int HR_WAIT_US = 100;
    localparam int HR_CYCLES = HR_WAIT_US * CYC_PER_US;
    localparam int HICCUP_OFF_US = 2000;
    localparam int HICCUP_CYCLES = HICCUP_OFF_US * CYC_PER_US;
    localparam int DEGLITCH_CYC = 4;
    localparam logic [7:0] SS_FULL = 8'hff;

    localparam logic [7:0] ADDR_LDC_CFG = 8'h18;
    localparam logic [7:0] ADDR_LDC_EXT = 8'h1e;
    localparam logic [7:0] ADDR_ILIM = 8'h20;
    localparam logic [7:0] ADDR_PEAK = 8'h21;
    localparam logic [7:0] ADDR_CTRL = 8'h22;
    localparam logic [7:0] ADDR_STAT = 8'h23;
    localparam int LDC_SEL_LSB = 1;
    localparam int LDC_ALT_BIT = 6;
    localparam int CTRL_CDP_BIT = 0;
    localparam logic [7:0] REG_RST = 8'h00;

    localparam logic [6:0] ILIM_MAX_CODE = 7'h6b;
    localparam logic [7:0] LDC_FULL_LOAD = 8'h3c;
    localparam logic [9:0] LDC_STD_0 = 10'h096;
    localparam logic [9:0] LDC_STD_1 = 10'h12c;
    localparam logic [9:0] LDC_STD_2 = 10'h258;
    localparam logic [9:0] LDC_ALT_0 = 10'h12c;
    localparam logic [9:0] LDC_ALT_1 = 10'h1c2;
    localparam logic [9:0] LDC_ALT_2 = 10'h2ee;

    typedef struct packed {
        logic oc;
        logic uv;
        logic ovp_rel_hi;
        logic ovp_rel_lo;
        logic ovp_abs;
        logic vin_ovp_hi;
        logic vin_ovp_lo;
        logic ot_hi;
        logic ot_lo;
        logic ss_above_ref;
        logic ss_above_fb;
        logic dl_divider;
        logic dl_bc12;
        logic dl_hv_req;
        logic dl_released;
    } pcm_flags_t;

    typedef struct packed {
        logic input_high_side_switch;
        logic input_low_side_switch;
        logic output_low_side_switch;
        logic output_high_side_switch;
    } pcm_sw_t;

    typedef enum logic [1:0] {
        MODE_BUCK = 2'h0,
        MODE_BOOST = 2'h1,
        MODE_BB = 2'h2
    } pcm_conv_mode_t;

    typedef enum logic [3:0] {
        DL_DIVIDER = 4'h1,
        DL_DCP = 4'h2,
        DL_HV = 4'h4,
        DL_CDP = 4'h8
    } pcm_dl_mode_t;

    typedef enum logic [4:0] {
        PS_OFF = 5'h01,
        PS_SS = 5'h02,
        PS_RUN = 5'h04,
        PS_HRW = 5'h08,
        PS_HICCUP = 5'h10
    } pcm_prot_state_t;
endpackage

// file: src/pcm_sync_filter.sv
// Three-stage synchroniser and deglitch filter for asynchronous comparator flags.
// Assumes the flags may change at any time relative to clk_sys.
`timescale 1ns/1ps
module pcm_sync_filter #(
    parameter int W = 15,
    parameter int DG = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    initial begin
        if (W < 1 || DG < 1 || DG > 255) begin
            $error("pcm_sync_filter: bad parameters");
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg, s2_reg, s3_reg, q_reg;
            logic [7:0] cnt_reg;
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end else if (ce) begin
                    s1_reg <= d[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            // A change is only accepted after it has held for DG agreeing samples.
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    cnt_reg <= 8'h00;
                    q_reg <= 1'b0;
                end else if (ce) begin
                    if (s2_reg != s3_reg || s3_reg == q_reg) begin
                        cnt_reg <= 8'h00;
                    end else if (cnt_reg == 8'(DG - 1)) begin
                        cnt_reg <= 8'h00;
                        q_reg <= s3_reg;
                    end else begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
            end
            assign q[i] = q_reg;
        end
    endgenerate
endmodule

// file: src/pcm_legacy_detect.sv
// Legacy charging-scheme detection state machine on the data lines.
// Assumes its sense inputs are already synchronised and deglitched.
`timescale 1ns/1ps
module pcm_legacy_detect (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic bc12,
    input wire logic hv_req,
    input wire logic released,
    input wire logic downstream_port_handshake_enable,
    input wire logic pd_contract,
    output pcm_pkg::pcm_dl_mode_t mode
);
    pcm_pkg::pcm_dl_mode_t mode_reg, mode_next;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            pcm_pkg::DL_DIVIDER: begin
                // Divider-compliant sinks simply leave the lines alone here.
                if (bc12) begin
                    mode_next = downstream_port_handshake_enable ? pcm_pkg::DL_CDP : pcm_pkg::DL_DCP;
                end
            end
            pcm_pkg::DL_DCP: begin
                if (released) begin
                    mode_next = pcm_pkg::DL_DIVIDER;
                end else if (hv_req && !pd_contract) begin
                    mode_next = pcm_pkg::DL_HV;
                end
            end
            pcm_pkg::DL_CDP: begin
                if (released || !downstream_port_handshake_enable) begin
                    mode_next = pcm_pkg::DL_DIVIDER;
                end
            end
            pcm_pkg::DL_HV: begin
                if (released || pd_contract) begin
                    mode_next = pcm_pkg::DL_DIVIDER;
                end
            end
            default: mode_next = pcm_pkg::DL_DIVIDER;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode_reg <= pcm_pkg::DL_DIVIDER;
        end else if (ce) begin
            mode_reg <= mode_next;
        end
    end
    assign mode = mode_reg;
endmodule

// file: src/pcm_protect_top.sv
// Protection sequencing and charge-mode control for a buck-boost USB-C source.
// Assumes analog comparators, PD engine and PWM modulator sit outside.
`timescale 1ns/1ps
module pcm_protect_top #(
    parameter int SS_CYC = pcm_pkg::SS_CYCLES,
    parameter int HICCUP_CYC = pcm_pkg::HICCUP_CYCLES,
    parameter int HR_CYC = pcm_pkg::HR_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input pcm_pkg::pcm_flags_t flags_async,
    input pcm_pkg::pcm_conv_mode_t conv_mode,
    input wire logic pdo_pps,
    input wire logic pd_contract,
    input wire logic [7:0] iout_code,
    input wire logic otp_vin_ovp_en,
    input wire logic otp_pps_ldc_en,
    input wire logic [7:0] otp_peak_code,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    output pcm_pkg::pcm_sw_t sw_en,
    output logic discharge_en,
    output logic chip_shutdown,
    output logic cc_limit_active,
    output logic hard_reset_req,
    output logic hiccup_active,
    output logic [7:0] ss_level,
    output logic ea_fixed_ref,
    output logic valley_limit_en,
    output logic [7:0] peak_code,
    output logic [6:0] ilim_code,
    output logic [9:0] ldc_mv,
    output logic boot_charge_path_one,
    output logic boot_charge_path_two,
    output pcm_pkg::pcm_dl_mode_t dl_mode
);
    initial begin
        if (SS_CYC < 256 || HICCUP_CYC < 1 || HR_CYC < 1 || SS_CYC > 65535 ||
            HICCUP_CYC > 65535 || HR_CYC > 65535) begin
            $error("pcm_protect_top: timing parameters out of range");
        end
    end
    localparam logic [15:0] SS_STEP = 16'(SS_CYC / 255);

    pcm_pkg::pcm_flags_t f;
    pcm_pkg::pcm_prot_state_t st_reg, st_next;
    logic [15:0] tmr_reg;
    logic [7:0] ldc_cfg_reg, ldc_ext_reg, ctrl_reg, peak_reg, rdata_reg;
    logic [6:0] ilim_reg;
    logic peak_wr_reg, oc_d_reg, uv_d_reg, prebias_ok_reg;
    logic ovp_rel_reg, vin_ovp_reg, ot_reg;
    logic hr_reg, hic_reg, dis_reg, fixref_reg, valley_reg;
    logic [7:0] ss_reg;
    logic [9:0] ldc_reg;
    logic bst1_reg, bst2_reg;
    logic [7:0] peak_out_reg;
    pcm_pkg::pcm_sw_t sw_reg;
    logic sw_gate, hr_fire;

    pcm_sync_filter #(
        .W($bits(pcm_pkg::pcm_flags_t)),
        .DG(pcm_pkg::DEGLITCH_CYC)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .d(flags_async),
        .q(f)
    );

    pcm_legacy_detect u_legacy (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .bc12(f.dl_bc12),
        .hv_req(f.dl_hv_req),
        .released(f.dl_released),
        .downstream_port_handshake_enable(ctrl_reg[pcm_pkg::CTRL_CDP_BIT]),
        .pd_contract(pd_contract),
        .mode(dl_mode)
    );

    function automatic logic [9:0] ldc_full(input logic [1:0] sel, input logic alt);
        logic [9:0] v;
        v = 10'h000;
        case (sel)
            2'h0: v = alt ? pcm_pkg::LDC_ALT_0 : pcm_pkg::LDC_STD_0;
            2'h1: v = alt ? pcm_pkg::LDC_ALT_1 : pcm_pkg::LDC_STD_1;
            default: v = alt ? pcm_pkg::LDC_ALT_2 : pcm_pkg::LDC_STD_2;
        endcase
        return v;
    endfunction

    // Register writes; the current-limit code is clamped so 6.35A is never exceeded.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ldc_cfg_reg <= pcm_pkg::REG_RST;
            ldc_ext_reg <= pcm_pkg::REG_RST;
            ctrl_reg <= pcm_pkg::REG_RST;
            ilim_reg <= pcm_pkg::ILIM_MAX_CODE;
            peak_reg <= pcm_pkg::REG_RST;
            peak_wr_reg <= 1'b0;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                pcm_pkg::ADDR_LDC_CFG: ldc_cfg_reg <= reg_wdata;
                pcm_pkg::ADDR_LDC_EXT: ldc_ext_reg <= reg_wdata;
                pcm_pkg::ADDR_CTRL: ctrl_reg <= reg_wdata;
                pcm_pkg::ADDR_ILIM: begin
                    ilim_reg <= (reg_wdata[6:0] > pcm_pkg::ILIM_MAX_CODE) ?
                        pcm_pkg::ILIM_MAX_CODE : reg_wdata[6:0];
                end
                pcm_pkg::ADDR_PEAK: begin
                    peak_reg <= reg_wdata;
                    peak_wr_reg <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else if (ce) begin
            case (reg_addr)
                pcm_pkg::ADDR_LDC_CFG: rdata_reg <= ldc_cfg_reg;
                pcm_pkg::ADDR_LDC_EXT: rdata_reg <= ldc_ext_reg;
                pcm_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
                pcm_pkg::ADDR_ILIM: rdata_reg <= {1'b0, ilim_reg};
                pcm_pkg::ADDR_PEAK: rdata_reg <= peak_code;
                pcm_pkg::ADDR_STAT: begin
                    rdata_reg <= {1'b0, hic_reg, ot_reg, vin_ovp_reg, ovp_rel_reg,
                        f.ovp_abs, cc_limit_active, fixref_reg};
                end
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // Fault latches with hysteresis; a hot die forces the sequencer to the off state.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ovp_rel_reg <= 1'b0;
            vin_ovp_reg <= 1'b0;
            ot_reg <= 1'b0;
            oc_d_reg <= 1'b0;
            uv_d_reg <= 1'b0;
        end else if (ce) begin
            if (f.ovp_rel_hi) begin
                ovp_rel_reg <= 1'b1;
            end else if (!f.ovp_rel_lo) begin
                ovp_rel_reg <= 1'b0;
            end
            if (otp_vin_ovp_en && f.vin_ovp_hi) begin
                vin_ovp_reg <= 1'b1;
            end else if (!otp_vin_ovp_en || !f.vin_ovp_lo) begin
                vin_ovp_reg <= 1'b0;
            end
            if (f.ot_hi) begin
                ot_reg <= 1'b1;
            end else if (!f.ot_lo) begin
                ot_reg <= 1'b0;
            end
            oc_d_reg <= f.oc;
            uv_d_reg <= f.uv;
        end
    end

    assign hr_fire = (st_reg == pcm_pkg::PS_RUN || (st_reg == pcm_pkg::PS_SS && !hic_reg)) &&
        ((!pdo_pps && f.oc && !oc_d_reg) || (pdo_pps && f.uv && !uv_d_reg));

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            pcm_pkg::PS_OFF: begin
                if (!ot_reg) begin
                    st_next = pcm_pkg::PS_SS;
                end
            end
            pcm_pkg::PS_SS: begin
                if (hr_fire) begin
                    st_next = pcm_pkg::PS_HRW;
                end else if (ss_reg == pcm_pkg::SS_FULL && tmr_reg == SS_STEP) begin
                    st_next = (hic_reg && f.oc) ? pcm_pkg::PS_HICCUP : pcm_pkg::PS_RUN;
                end
            end
            pcm_pkg::PS_RUN: begin
                if (hr_fire) begin
                    st_next = pcm_pkg::PS_HRW;
                end
            end
            pcm_pkg::PS_HRW: begin
                if (tmr_reg == 16'(HR_CYC - 1)) begin
                    st_next = f.oc ? pcm_pkg::PS_HICCUP : pcm_pkg::PS_RUN;
                end
            end
            pcm_pkg::PS_HICCUP: begin
                if (tmr_reg == 16'(HICCUP_CYC - 1)) begin
                    st_next = pcm_pkg::PS_SS;
                end
            end
            default: st_next = pcm_pkg::PS_OFF;
        endcase
        if (ot_reg) begin
            st_next = pcm_pkg::PS_OFF;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_reg <= pcm_pkg::PS_OFF;
            tmr_reg <= 16'h0000;
        end else if (ce) begin
            st_reg <= st_next;
            if (st_next != st_reg || (st_reg == pcm_pkg::PS_SS && tmr_reg == SS_STEP)) begin
                tmr_reg <= 16'h0000;
            end else begin
                tmr_reg <= tmr_reg + 16'h0001;
            end
        end
    end

    // Soft-start ramp; the reference hands over once the ramp passes it.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ss_reg <= 8'h00;
            fixref_reg <= 1'b0;
            prebias_ok_reg <= 1'b0;
        end else if (ce) begin
            if (st_reg != pcm_pkg::PS_SS && st_reg != pcm_pkg::PS_RUN &&
                st_reg != pcm_pkg::PS_HRW) begin
                ss_reg <= 8'h00;
                fixref_reg <= 1'b0;
                prebias_ok_reg <= 1'b0;
            end else begin
                if (st_reg == pcm_pkg::PS_SS && tmr_reg == SS_STEP &&
                    ss_reg != pcm_pkg::SS_FULL) begin
                    ss_reg <= ss_reg + 8'h01;
                end
                if (f.ss_above_ref || st_reg == pcm_pkg::PS_RUN) begin
                    fixref_reg <= 1'b1;
                end
                if (f.ss_above_fb) begin
                    prebias_ok_reg <= 1'b1;
                end
            end
        end
    end

    // Pre-bias holds switching off; the soft-start restarts at zero after off or hiccup, not after a hard-reset wait.
    assign sw_gate = prebias_ok_reg && !ovp_rel_reg && !vin_ovp_reg && !f.ovp_abs &&
        (st_reg == pcm_pkg::PS_SS || st_reg == pcm_pkg::PS_RUN);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sw_reg <= '0;
            dis_reg <= 1'b0;
            hr_reg <= 1'b0;
            hic_reg <= 1'b0;
            valley_reg <= 1'b0;
            bst1_reg <= 1'b0;
            bst2_reg <= 1'b0;
            peak_out_reg <= otp_peak_code;
        end else if (ce) begin
            peak_out_reg <= peak_wr_reg ? peak_reg : otp_peak_code;
            sw_reg <= {4{sw_gate}};
            dis_reg <= ovp_rel_reg || f.ovp_abs;
            hr_reg <= hr_fire;
            if (st_reg == pcm_pkg::PS_HICCUP) begin
                hic_reg <= 1'b1;
            end else if (st_reg == pcm_pkg::PS_RUN || st_reg == pcm_pkg::PS_OFF) begin
                hic_reg <= 1'b0;
            end
            valley_reg <= conv_mode != pcm_pkg::MODE_BOOST;
            bst1_reg <= conv_mode == pcm_pkg::MODE_BOOST;
            bst2_reg <= conv_mode == pcm_pkg::MODE_BUCK;
        end
    end

    // Compensation grows linearly with load to the full value at 3A.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ldc_reg <= 10'h000;
        end else if (ce) begin
            if (pdo_pps && !otp_pps_ldc_en) begin
                ldc_reg <= 10'h000;
            end else if (iout_code >= pcm_pkg::LDC_FULL_LOAD) begin
                ldc_reg <= ldc_full(ldc_cfg_reg[pcm_pkg::LDC_SEL_LSB +: 2],
                    ldc_ext_reg[pcm_pkg::LDC_ALT_BIT]);
            end else begin
                ldc_reg <= 10'((18'(ldc_full(ldc_cfg_reg[pcm_pkg::LDC_SEL_LSB +: 2],
                    ldc_ext_reg[pcm_pkg::LDC_ALT_BIT])) * 18'(iout_code)) /
                    18'(pcm_pkg::LDC_FULL_LOAD));
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign sw_en = sw_reg;
    assign discharge_en = dis_reg;
    assign chip_shutdown = ot_reg;
    assign cc_limit_active = oc_d_reg;
    assign hard_reset_req = hr_reg;
    assign hiccup_active = hic_reg;
    assign ss_level = ss_reg;
    assign ea_fixed_ref = fixref_reg;
    assign valley_limit_en = valley_reg;
    assign peak_code = peak_out_reg;
    assign ilim_code = ilim_reg;
    assign ldc_mv = ldc_reg;
    assign boot_charge_path_one = bst1_reg;
    assign boot_charge_path_two = bst2_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_hr_fixed_oc: assert property (ce && st_reg == pcm_pkg::PS_RUN && !pdo_pps &&
        f.oc && !oc_d_reg |=> hard_reset_req ##1 !hard_reset_req)
        else $error("fixed offer overcurrent did not request one hard reset");
    a_hr_pps_uv: assert property (ce && st_reg == pcm_pkg::PS_RUN && pdo_pps &&
        f.uv && !uv_d_reg |=> hard_reset_req)
        else $error("augmented offer under-voltage did not request hard reset");
    a_ovp_sw_off: assert property (ce && f.ovp_rel_hi |=> ovp_rel_reg ##1
        (sw_en == '0 || !ce) && (discharge_en || !ce))
        else $error("relative overvoltage left switches on");
    a_abs_ovp_dis: assert property (ce && f.ovp_abs |=> discharge_en)
        else $error("absolute overvoltage without discharge");
    a_vin_ovp_gate: assert property (!otp_vin_ovp_en && ce |=> !vin_ovp_reg)
        else $error("input overvoltage active while not enabled");
    a_vin_ovp_trip: assert property (ce && otp_vin_ovp_en && f.vin_ovp_hi |=>
        vin_ovp_reg ##1 (sw_en == '0 || !ce))
        else $error("input overvoltage left switches on");
    a_thermal_off: assert property (ce && f.ot_hi |=> chip_shutdown ##1
        (st_reg == pcm_pkg::PS_OFF || !ce))
        else $error("overtemperature did not shut down");
    a_prebias_hold: assert property (st_reg == pcm_pkg::PS_SS && !prebias_ok_reg |=>
        sw_en == '0)
        else $error("switching during pre-biased start");
    a_ldc_pps_off: assert property (ce && pdo_pps && !otp_pps_ldc_en |=>
        ldc_mv == 10'h000)
        else $error("compensation applied in augmented mode");
    a_ldc_zero_load: assert property (ce && iout_code == 8'h00 |=> ldc_mv == 10'h000)
        else $error("compensation at zero load");
    a_ilim_range: assert property (ilim_code <= pcm_pkg::ILIM_MAX_CODE)
        else $error("current limit code above 6.35A");
    a_valley_boost: assert property (ce && conv_mode == pcm_pkg::MODE_BOOST |=>
        !valley_limit_en)
        else $error("valley limit active in boost");
    a_hv_pd_exit: assert property (ce && pd_contract |=> dl_mode != pcm_pkg::DL_HV)
        else $error("quick charge mode kept under PD contract");

    c_hiccup: cover property (st_reg == pcm_pkg::PS_HICCUP);
    c_hv_mode: cover property (dl_mode == pcm_pkg::DL_HV);
    c_ovp_resume: cover property (ovp_rel_reg ##1 !ovp_rel_reg);
    c_run_reached: cover property (st_reg == pcm_pkg::PS_RUN && sw_en != '0);
endmodule

// file: verification/pcm_sink_model.sv
// Behavioural charging sink seen on the data lines and the PD contract.
// Assumes the bench picks the sink kind; the lines move after a falling edge.
`timescale 1ns/1ps
module pcm_sink_model (
    input wire logic clk_sys,
    input wire logic [1:0] kind,
    input wire logic pd,
    output logic bc12,
    output logic hv_req,
    output logic released,
    output logic pd_contract
);
    // Kind 0 has let go of the lines, 1 is a divider sink, 2 BC1.2, 3 quick charge.
    always @(negedge clk_sys) begin
        released <= (kind == 2'h0);
        bc12 <= (kind >= 2'h2);
        hv_req <= (kind == 2'h3) && !pd;
        pd_contract <= pd;
    end
endmodule

// file: verification/pcm_protect_top_bench.sv
// Self-checking bench for the protection and charge-mode control block.
// Assumes shortened soft-start, hard-reset and hiccup counts.
`timescale 1ns/1ps
module pcm_protect_top_bench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    // Order: oc uv ovp_rel_hi ovp_rel_lo ovp_abs vin_hi vin_lo ot_hi ot_lo ss_ref ss_fb.
    logic [10:0] an = 11'h000;
    logic [1:0] kind = 2'h1;
    logic pd = 1'b0;
    pcm_pkg::pcm_conv_mode_t conv_mode = pcm_pkg::MODE_BUCK;
    logic pdo_pps = 1'b0;
    logic otp_vin_ovp_en = 1'b0;
    logic otp_pps_ldc_en = 1'b0;
    logic [7:0] otp_peak_code = 8'h40;
    logic [7:0] iout_code = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic dl_bc12, dl_hv_req, dl_released, pd_contract;
    logic [7:0] reg_rdata;
    pcm_pkg::pcm_sw_t sw_en;
    logic discharge_en, chip_shutdown, cc_limit_active, hard_reset_req;
    logic hiccup_active, ea_fixed_ref, valley_limit_en;
    logic [6:0] ilim_code;
    logic [7:0] ss_level, peak_code;
    logic boot_charge_path_one, boot_charge_path_two;
    logic [9:0] ldc_mv;
    pcm_pkg::pcm_dl_mode_t dl_mode;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    pcm_sink_model u_pcm_sink_model (.clk_sys(clk_sys), .kind(kind), .pd(pd), .bc12(dl_bc12),
        .hv_req(dl_hv_req), .released(dl_released), .pd_contract(pd_contract));
    pcm_protect_top #(.SS_CYC(512), .HICCUP_CYC(300), .HR_CYC(50)) u_pcm_protect_top (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .flags_async({an, kind == 2'h1, dl_bc12, dl_hv_req, dl_released}),
        .conv_mode(conv_mode), .pdo_pps(pdo_pps), .pd_contract(pd_contract),
        .iout_code(iout_code), .otp_vin_ovp_en(otp_vin_ovp_en), .otp_pps_ldc_en(otp_pps_ldc_en),
        .otp_peak_code(otp_peak_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .sw_en(sw_en), .discharge_en(discharge_en),
        .chip_shutdown(chip_shutdown), .cc_limit_active(cc_limit_active),
        .hard_reset_req(hard_reset_req), .hiccup_active(hiccup_active), .ss_level(ss_level),
        .ea_fixed_ref(ea_fixed_ref), .valley_limit_en(valley_limit_en), .peak_code(peak_code),
        .ilim_code(ilim_code), .ldc_mv(ldc_mv), .boot_charge_path_one(boot_charge_path_one),
        .boot_charge_path_two(boot_charge_path_two), .dl_mode(dl_mode));
    initial forever #50 clk_sys = ~clk_sys;
    task automatic run(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        run(1);
        reg_wr = 1'b0;
        run(1);
    endtask
    task automatic hr_count();
        n = 0;
        repeat (20) begin
            run(1);
            n += int'(hard_reset_req);
        end
    endtask
    task automatic leg(input logic [1:0] k, input logic p, input logic [3:0] e);
        kind = k;
        pd = p;
        run(14);
        chk("dl_mode", 10'(e), 10'(dl_mode));
    endtask
    function automatic int ldc_exp(int sel, int alt, int i, bit sup);
        int f;
        f = (sel == 0 ? 150 : sel == 1 ? 300 : 600) + (alt ? 150 : 0);
        return sup ? 0 : f * (i > 60 ? 60 : i) / 60;
    endfunction
    task automatic report_and_stop();
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        n = $urandom(74698);
        run(5);
        rstn = 1'b1;
        run(1);
        chk("ilim", 107, 10'(ilim_code));
        chk("dl_rst", 1, 10'(dl_mode));
        chk("peak_otp", 10'h40, 10'(peak_code));
        an[1] = 1'b1;
        run(100);
        chk("prebias", 0, 10'(sw_en));
        an[0] = 1'b1;
        run(700);
        chk("sw_run", 10'hf, 10'(sw_en));
        chk("fixref", 1, 10'(ea_fixed_ref));
        chk("ss_full", 10'hff, 10'(ss_level));
        an[10] = 1'b1;
        hr_count();
        chk("hr_fixed", 1, 10'(n));
        chk("cc", 1, 10'(cc_limit_active));
        run(60);
        chk("hiccup", 1, 10'(hiccup_active));
        an[10] = 1'b0;
        run(1200);
        chk("hic_end", 0, 10'(hiccup_active));
        pdo_pps = 1'b1;
        an[9] = 1'b1;
        hr_count();
        chk("hr_pps", 1, 10'(n));
        an[9] = 1'b0;
        an[8:7] = 2'h3;
        run(100);
        chk("ovp_sw", 0, 10'(sw_en));
        chk("ovp_dis", 1, 10'(discharge_en));
        an[8] = 1'b0;
        run(12);
        chk("ovp_hold", 0, 10'(sw_en));
        an[7] = 1'b0;
        run(12);
        chk("ovp_end", 0, 10'(discharge_en));
        an[6] = 1'b1;
        run(12);
        chk("abs_dis", 1, 10'(discharge_en));
        an[6] = 1'b0;
        for (int v = 0; v < 2; v++) begin
            otp_vin_ovp_en = v[0];
            an[5:4] = 2'h3;
            run(12);
            chk("vin_ovp", v ? 10'h0 : 10'hf, 10'(sw_en));
            an[5:4] = 2'h0;
            run(12);
            chk("vin_end", 10'hf, 10'(sw_en));
        end
        an[3:2] = 2'h3;
        run(12);
        chk("ot", 1, 10'(chip_shutdown));
        an[3] = 1'b0;
        run(12);
        chk("ot_hold", 1, 10'(chip_shutdown));
        an[2] = 1'b0;
        run(12);
        chk("ot_end", 0, 10'(chip_shutdown));
        wreg(pcm_pkg::ADDR_ILIM, 8'h10);
        chk("ilim_rd", 10'h10, 10'(reg_rdata));
        wreg(pcm_pkg::ADDR_ILIM, 8'hff);
        chk("ilim_max", 107, 10'(ilim_code));
        ce = 1'b0;
        wreg(pcm_pkg::ADDR_ILIM, 8'h05);
        chk("ce_hold", 107, 10'(ilim_code));
        ce = 1'b1;
        wreg(pcm_pkg::ADDR_PEAK, 8'h5a);
        chk("peak_wr", 10'h5a, 10'(peak_code));
        wreg(8'h7f, 8'h55);
        chk("unmapped", 0, 10'(reg_rdata));
        for (int k = 0; k < 24; k++) begin
            pdo_pps = (k >= 16);
            otp_pps_ldc_en = (k >= 20);
            iout_code = (k < 4) ? 8'(k * 30) : 8'($urandom_range(120));
            wreg(pcm_pkg::ADDR_LDC_CFG, 8'(k % 4 * 2));
            wreg(pcm_pkg::ADDR_LDC_EXT, k[2] ? 8'h40 : 8'h00);
            n = ldc_exp(k % 4, k[2], iout_code, pdo_pps && !otp_pps_ldc_en);
            chk("ldc", 10'(n), ldc_mv);
        end
        for (int m = 0; m < 3; m++) begin
            conv_mode = pcm_pkg::pcm_conv_mode_t'(m);
            run(2);
            chk("valley", 10'(m != 1), 10'(valley_limit_en));
            chk("boot1", 10'(m == 1), 10'(boot_charge_path_one));
            chk("boot2", 10'(m == 0), 10'(boot_charge_path_two));
        end
        leg(2'h2, 1'b0, 4'h2);
        leg(2'h3, 1'b0, 4'h4);
        leg(2'h3, 1'b1, 4'h2);
        leg(2'h0, 1'b0, 4'h1);
        wreg(pcm_pkg::ADDR_CTRL, 8'h01);
        leg(2'h2, 1'b0, 4'h8);
        leg(2'h0, 1'b0, 4'h1);
        report_and_stop();
    end
endmodule
